/* File: logic/mpli_link.sv */
// mii link end of the network interface: byte streams on clock_i, phy pins
// on the phy-made transmit and receive clocks, gray rings between domains.
// assumes tx_clk_i and rx_clk_i come from the phy and may stop between frames.
// Functional notes
// [R1] transmit valid and transmit data change on falling edges of the transmit clock.
// [R2] the phy samples transmit valid and data on rising edges of the transmit clock.
// [R3] the phy changes receive valid, receive data and collision on falling receive clock edges.
// [R4] receive valid, receive data and collision are sampled on rising receive clock edges.
// [R5] the link has transmit clock, valid and four data lines, and receive clock, valid, four data and collision.
// [R6] the collision line is captured as a receive input and marks the frame in error.
// [R7] serial mode moves one bit per clock on data line 0 in each direction for 10 Mbps.
// [R8] nibble mode moves four bits per clock on data lines 0 to 3 in each direction.
// [R9] the phy runs nibble clocks at 2.5 MHz for 10 Mbps and 25 MHz for 100 Mbps.
// [R10] both serial and nibble modes are supported.
// [R11] every sent frame starts with 62 alternating bits from a one, then two one bits.
// [R12] the data field holds 64 to 1518 bytes and transmit valid stays low between frames; a transmit underrun can end a frame under 64 bytes.
// [R13] no management clock or data pins exist, the phy is never configured from here.
// [R14] link, serial and duplex state come from active-low status pins fed by the phy.
// [R15] any run-time phy management is the host's own job over its management pins.
// [R16] serial mode is used while the serial status pin is low, nibble mode otherwise.
// [R17] in nibble mode each byte goes low nibble first with the lsb on line 0.

// word crossing with gray pointers, one entry per byte
module mpli_cdc_ring #(
   parameter int W  = 9,
   parameter int AW = 2
) (
   input  wire logic         wclk_i,     // write side clock
   input  wire logic         wrstn_i,    // write side reset
   input  wire logic         w_push_i,   // write strobe
   input  wire logic [W-1:0] w_data_i,   // write word
   output logic              w_ready_o,  // room for a word
   input  wire logic         rclk_i,     // read side clock
   input  wire logic         rrstn_i,    // read side reset
   input  wire logic         r_pop_i,    // read strobe
   output logic [W-1:0]      r_data_o,   // head word
   output logic              r_empty_o   // nothing to read
);
   logic [W-1:0] mem [2**AW];
   logic [AW:0]  wbin, wgray, rg_m, rg_s, next_wbin;
   logic [AW:0]  rbin, rgray, wg_m, wg_s, next_rbin;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   assign next_wbin = wbin + ((w_push_i && w_ready_o) ? 1'b1 : 1'b0);
   assign next_rbin = rbin + ((r_pop_i && !r_empty_o) ? 1'b1 : 1'b0);

   // storage has no reset, only written words are ever read
   always_ff @(posedge wclk_i)
   begin
      if (w_push_i && w_ready_o)
         mem[wbin[AW-1:0]] <= w_data_i;
   end

   // ready is judged on the stale read pointer, so it only errs toward full
   always_ff @(posedge wclk_i or negedge wrstn_i)
   begin
      if (!wrstn_i)
      begin
         wbin      <= '0;
         wgray     <= '0;
         rg_m      <= '0;
         rg_s      <= '0;
         w_ready_o <= 1'b0;
      end
      else
      begin
         wbin      <= next_wbin;
         wgray     <= to_gray(next_wbin);
         rg_m      <= rgray;
         rg_s      <= rg_m;
         w_ready_o <= to_gray(next_wbin) != {~rg_s[AW:AW-1], rg_s[AW-2:0]};
      end
   end

   always_ff @(posedge rclk_i or negedge rrstn_i)
   begin
      if (!rrstn_i)
      begin
         rbin  <= '0;
         rgray <= '0;
         wg_m  <= '0;
         wg_s  <= '0;
      end
      else
      begin
         rbin  <= next_rbin;
         rgray <= to_gray(next_rbin);
         wg_m  <= wgray;
         wg_s  <= wg_m;
      end
   end

   assign r_empty_o = (rgray == wg_s);
   assign r_data_o  = mem[rbin[AW-1:0]];
endmodule

// top: no management pins at all, the phy is strapped by the board  [R13]
module mpli_link #(
   parameter int AW = mpli_pkg::RING_AW
) (
   input  wire logic       clock_i,                // system clock
   input  wire logic       rstn_i,                 // async reset, low
   input  wire logic       tx_valid_i,             // frame byte offered
   input  wire logic [7:0] tx_data_i,              // frame byte
   input  wire logic       tx_last_i,              // last byte of frame
   output logic            tx_ready_o,             // byte taken when high
   output logic            rx_valid_o,             // received byte pulse
   output logic [7:0]      rx_data_o,              // received byte
   output logic            rx_last_o,              // last byte of frame
   output logic            rx_err_o,               // frame bad, with last
   output logic            link_up_o,              // link status
   output logic            serial_mode_o,          // serial lane mode
   output logic            full_duplex_o,          // duplex status
   input  wire logic       link_status_n_i,        // phy link led, low
   input  wire logic       serial_status_n_i,      // serial mode pin, low
   input  wire logic       full_duplex_status_n_i, // duplex led, low
   input  wire logic       tx_clk_i,               // phy transmit clock
   output logic            transmit_valid_out_o,   // frame on the wire
   output logic [3:0]      txd_o,                  // transmit lanes
   input  wire logic       rx_clk_i,               // phy receive clock
   input  wire logic       rxdv_i,                 // receive valid
   input  wire logic [3:0] rxd_i,                  // receive lanes
   input  wire logic       col_i                   // collision
);
   // reset release synchronised into each link domain
   logic [1:0] tx_rs, rx_rs;
   logic       tx_rstn, rx_rstn;
   assign tx_rstn = tx_rs[1];
   assign rx_rstn = rx_rs[1];

   always_ff @(posedge tx_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         tx_rs <= 2'h0;
      else
         tx_rs <= {tx_rs[0], 1'b1};
   end

   always_ff @(posedge rx_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rx_rs <= 2'h0;
      else
         rx_rs <= {rx_rs[0], 1'b1};
   end

   // status pins are asynchronous, two flops per reading domain
   logic [2:0] st_m;
   logic [1:0] txs_m, txs_s;
   logic       rxs_m, rxs_s;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_m          <= 3'h7;
         link_up_o     <= 1'b0;
         serial_mode_o <= 1'b0;
         full_duplex_o <= 1'b0;
      end
      else
      begin
         st_m          <= {full_duplex_status_n_i, serial_status_n_i, link_status_n_i};
         link_up_o     <= ~st_m[0];   // R14
         serial_mode_o <= ~st_m[1];   // R16
         full_duplex_o <= ~st_m[2];
      end
   end

   always_ff @(posedge tx_clk_i or negedge tx_rstn)
   begin
      if (!tx_rstn)
      begin
         txs_m <= 2'h0;
         txs_s <= 2'h0;
      end
      else
      begin
         txs_m <= {~serial_status_n_i, ~link_status_n_i};
         txs_s <= txs_m;
      end
   end

   always_ff @(posedge rx_clk_i or negedge rx_rstn)
   begin
      if (!rx_rstn)
      begin
         rxs_m <= 1'b0;
         rxs_s <= 1'b0;
      end
      else
      begin
         rxs_m <= ~serial_status_n_i;
         rxs_s <= rxs_m;
      end
   end

   // transmit crossing: system writes bytes, link side drains them
   mpli_pkg::mpli_tx_ent_t tx_ent;
   logic                   tx_empty, tx_pop;

   mpli_cdc_ring #(.W(9), .AW(AW)) u_tx_ring (
      .wclk_i    (clock_i),
      .wrstn_i   (rstn_i),
      .w_push_i  (tx_valid_i),
      .w_data_i  ({tx_last_i, tx_data_i}),
      .w_ready_o (tx_ready_o),
      .rclk_i    (tx_clk_i),
      .rrstn_i   (tx_rstn),
      .r_pop_i   (tx_pop),
      .r_data_o  (tx_ent),
      .r_empty_o (tx_empty)
   );

   // transmit sequencer: one byte shifter serves both lane modes
   mpli_pkg::mpli_tx_st_t tx_st, next_tx_st;
   logic [7:0]            tx_sh, next_tx_sh;
   logic [2:0]            tx_pos, next_tx_pos;
   logic [10:0]           tx_cnt, next_tx_cnt, tx_cnt_n;
   logic                  tx_ser, next_tx_ser, tx_done, next_tx_done;
   logic                  tx_drop, next_tx_drop, tx_bend;
   logic [7:0]            tx_shift;
   logic [3:0]            tx_bits;

   assign tx_bend  = (tx_pos == (tx_ser ? mpli_pkg::SER_LAST : mpli_pkg::NIB_LAST));
   assign tx_cnt_n = tx_cnt + 11'h001;
   assign tx_shift = tx_ser ? {1'b0, tx_sh[7:1]} : {4'h0, tx_sh[7:4]};          // R17
   assign tx_bits  = tx_ser ? {3'h0, tx_sh[0]} : tx_sh[3:0];                   // R7 R8

   always_comb
   begin
      next_tx_st   = tx_st;
      next_tx_sh   = tx_sh;
      next_tx_pos  = tx_bend ? 3'h0 : tx_pos + 3'h1;
      next_tx_cnt  = tx_cnt;
      next_tx_ser  = tx_ser;
      next_tx_done = tx_done;
      next_tx_drop = tx_drop;
      tx_pop       = 1'b0;
      case (tx_st)
         // idle keeps valid low; a cut frame's tail is flushed here
         mpli_pkg::TX_IDLE:
         begin
            next_tx_pos = 3'h0;
            next_tx_cnt = 11'h000;
            if (tx_drop)
            begin
               tx_pop = !tx_empty;
               if (!tx_empty && tx_ent.last)
                  next_tx_drop = 1'b0;
            end
            else if (!tx_empty && txs_s[0])                                  // R14
            begin
               next_tx_st   = mpli_pkg::TX_PRE;
               next_tx_sh   = mpli_pkg::PRE_BYTE;                            // R11
               next_tx_ser  = txs_s[1];                                      // R16 R10
               next_tx_done = 1'b0;
            end
         end
         mpli_pkg::TX_PRE:
         begin
            next_tx_sh = tx_shift;
            if (tx_bend)
            begin
               next_tx_cnt = tx_cnt_n;
               if (tx_cnt[2:0] == mpli_pkg::PRE_BYTES - 3'h1)
                  next_tx_sh = mpli_pkg::SFD_BYTE;                           // R11
               else if (tx_cnt[2:0] == mpli_pkg::PRE_BYTES)
               begin
                  next_tx_st   = mpli_pkg::TX_DATA;
                  tx_pop       = 1'b1;
                  next_tx_sh   = tx_ent.data;
                  next_tx_done = tx_ent.last;
                  next_tx_cnt  = 11'h000;
               end
               else
                  next_tx_sh = mpli_pkg::PRE_BYTE;
            end
         end
         mpli_pkg::TX_DATA:
         begin
            next_tx_sh = tx_shift;
            if (tx_bend)
            begin
               next_tx_cnt = tx_cnt_n;
               if (tx_done && tx_cnt_n >= mpli_pkg::MIN_LEN)                 // R12
                  next_tx_st = mpli_pkg::TX_IDLE;
               else if (tx_cnt_n == mpli_pkg::MAX_LEN)                       // R12
               begin
                  next_tx_st   = mpli_pkg::TX_IDLE;
                  next_tx_drop = !tx_done;
               end
               else if (tx_done)
                  next_tx_sh = 8'h00;                                        // R12
               else if (tx_empty)
               begin
                  // underrun: the frame is cut short, its tail discarded
                  next_tx_st   = mpli_pkg::TX_IDLE;
                  next_tx_drop = 1'b1;
               end
               else
               begin
                  tx_pop       = 1'b1;
                  next_tx_sh   = tx_ent.data;
                  next_tx_done = tx_ent.last;
               end
            end
         end
         default:
            next_tx_st = mpli_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge tx_clk_i or negedge tx_rstn)
   begin
      if (!tx_rstn)
      begin
         tx_st   <= mpli_pkg::TX_IDLE;
         tx_sh   <= 8'h00;
         tx_pos  <= 3'h0;
         tx_cnt  <= 11'h000;
         tx_ser  <= 1'b0;
         tx_done <= 1'b0;
         tx_drop <= 1'b0;
      end
      else
      begin
         tx_st   <= next_tx_st;
         tx_sh   <= next_tx_sh;
         tx_pos  <= next_tx_pos;
         tx_cnt  <= next_tx_cnt;
         tx_ser  <= next_tx_ser;
         tx_done <= next_tx_done;
         tx_drop <= next_tx_drop;
      end
   end

   // launch on the falling edge, half a period of setup for the phy
   always_ff @(negedge tx_clk_i or negedge tx_rstn)
   begin
      if (!tx_rstn)
      begin
         transmit_valid_out_o <= 1'b0;
         txd_o                <= 4'h0;
      end
      else
      begin
         transmit_valid_out_o <= (tx_st != mpli_pkg::TX_IDLE);               // R1 R12
         txd_o                <= tx_bits;                                    // R1 R5
      end
   end

   // receive pins are synchronous to rx_clk_i, one rising-edge sample
   mpli_pkg::mpli_rx_pins_t rxp;

   always_ff @(posedge rx_clk_i or negedge rx_rstn)
   begin
      if (!rx_rstn)
         rxp <= '0;
      else
         rxp <= {rxdv_i, col_i, rxd_i};                                      // R4 R5 R6
   end

   // receive deframer; last byte is held back until valid falls
   mpli_pkg::mpli_rx_st_t rx_st, next_rx_st;
   mpli_pkg::mpli_rx_ent_t rx_push_ent;
   logic [7:0]            rx_sh, next_rx_sh, rx_pend, next_rx_pend;
   logic [2:0]            rx_pos, next_rx_pos;
   logic [10:0]           rx_cnt, next_rx_cnt;
   logic                  rx_ser, next_rx_ser, rx_prev, next_rx_prev;
   logic                  rx_pv, next_rx_pv, rx_col, next_rx_col;
   logic                  rx_ovf, next_rx_ovf, rx_push, rx_ready, rx_bad;

   assign rx_bad = rx_col || rx_ovf || rx_pos != 3'h0 || rx_cnt < mpli_pkg::MIN_LEN
                   || rx_cnt > mpli_pkg::MAX_LEN;

   always_comb
   begin
      next_rx_st   = rx_st;
      next_rx_sh   = rx_sh;
      next_rx_pend = rx_pend;
      next_rx_pos  = rx_pos;
      next_rx_cnt  = rx_cnt;
      next_rx_ser  = rx_ser;
      next_rx_prev = rxp.d[0];
      next_rx_pv   = rx_pv;
      next_rx_col  = rx_col || rxp.col;                                      // R6
      next_rx_ovf  = rx_ovf;
      rx_push      = 1'b0;
      rx_push_ent  = {1'b0, 1'b0, rx_pend};
      case (rx_st)
         mpli_pkg::RX_IDLE:
         begin
            next_rx_col = rxp.col;
            if (rxp.dv)
            begin
               next_rx_st  = mpli_pkg::RX_PRE;
               next_rx_ser = rxs_s;                                          // R16 R10
               next_rx_pv  = 1'b0;
               next_rx_ovf = 1'b0;
               next_rx_cnt = 11'h000;
               next_rx_pos = 3'h0;
            end
         end
         mpli_pkg::RX_PRE:
         begin
            if (!rxp.dv)
               next_rx_st = mpli_pkg::RX_IDLE;
            else if (rx_ser ? (rx_prev && rxp.d[0]) : (rxp.d == mpli_pkg::SFD_NIB))
               next_rx_st = mpli_pkg::RX_DATA;                               // R7 R8
         end
         mpli_pkg::RX_DATA:
         begin
            if (!rxp.dv)
            begin
               next_rx_st  = mpli_pkg::RX_IDLE;
               rx_push     = rx_pv;
               rx_push_ent = {rx_bad, 1'b1, rx_pend};                        // R12 R6
            end
            else
            begin
               next_rx_sh  = rx_ser ? {rxp.d[0], rx_sh[7:1]} : {rxp.d, rx_sh[7:4]};
               next_rx_pos = rx_pos + 3'h1;
               if (rx_pos == (rx_ser ? mpli_pkg::SER_LAST : mpli_pkg::NIB_LAST))
               begin
                  next_rx_pos  = 3'h0;
                  rx_push      = rx_pv;
                  next_rx_pend = next_rx_sh;
                  next_rx_pv   = 1'b1;
                  if (rx_cnt != mpli_pkg::LEN_SAT)
                     next_rx_cnt = rx_cnt + 11'h001;
               end
            end
         end
         default:
            next_rx_st = mpli_pkg::RX_IDLE;
      endcase
      if (rx_push && !rx_ready)
         next_rx_ovf = 1'b1;
   end

   always_ff @(posedge rx_clk_i or negedge rx_rstn)
   begin
      if (!rx_rstn)
      begin
         rx_st   <= mpli_pkg::RX_IDLE;
         rx_sh   <= 8'h00;
         rx_pend <= 8'h00;
         rx_pos  <= 3'h0;
         rx_cnt  <= 11'h000;
         rx_ser  <= 1'b0;
         rx_prev <= 1'b0;
         rx_pv   <= 1'b0;
         rx_col  <= 1'b0;
         rx_ovf  <= 1'b0;
      end
      else
      begin
         rx_st   <= next_rx_st;
         rx_sh   <= next_rx_sh;
         rx_pend <= next_rx_pend;
         rx_pos  <= next_rx_pos;
         rx_cnt  <= next_rx_cnt;
         rx_ser  <= next_rx_ser;
         rx_prev <= next_rx_prev;
         rx_pv   <= next_rx_pv;
         rx_col  <= next_rx_col;
         rx_ovf  <= next_rx_ovf;
      end
   end

   // receive crossing; no back-pressure, a full ring loses bytes
   mpli_pkg::mpli_rx_ent_t rx_head;
   logic                   rx_empty;

   mpli_cdc_ring #(.W(10), .AW(AW)) u_rx_ring (
      .wclk_i    (rx_clk_i),
      .wrstn_i   (rx_rstn),
      .w_push_i  (rx_push),
      .w_data_i  (rx_push_ent),
      .w_ready_o (rx_ready),
      .rclk_i    (clock_i),
      .rrstn_i   (rstn_i),
      .r_pop_i   (!rx_empty),
      .r_data_o  (rx_head),
      .r_empty_o (rx_empty)
   );

   // one byte per system cycle, each shown as a one-cycle pulse
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
         rx_last_o  <= 1'b0;
         rx_err_o   <= 1'b0;
      end
      else
      begin
         rx_valid_o <= !rx_empty;
         rx_data_o  <= rx_head.data;
         rx_last_o  <= !rx_empty && rx_head.last;
         rx_err_o   <= !rx_empty && rx_head.err;
      end
   end

   // checks on the transmit domain
   AST_TX_LAUNCH: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R1
      txd_o == tx_bits && transmit_valid_out_o == (tx_st != mpli_pkg::TX_IDLE))
      else $error("transmit pins not launched from the prior falling edge");
   AST_TX_PREAMBLE: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R11
      (tx_st == mpli_pkg::TX_IDLE && next_tx_st == mpli_pkg::TX_PRE)
      |=> tx_sh == mpli_pkg::PRE_BYTE && tx_cnt == 11'h000)
      else $error("frame did not open with preamble");
   AST_TX_SFD: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R11
      (tx_st == mpli_pkg::TX_PRE && tx_bend && tx_cnt == 11'h006) |=> tx_sh == mpli_pkg::SFD_BYTE)
      else $error("delimiter not after seven preamble bytes");
   AST_TX_SERIAL_LANE: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R7
      tx_ser |-> txd_o[3:1] == 3'h0)
      else $error("serial mode drove lanes above 0");
   AST_TX_HIGH_NIB: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R17
      (!tx_ser && tx_st != mpli_pkg::TX_IDLE && tx_pos == 3'h0) |=> tx_bits == $past(tx_sh[7:4]))
      else $error("high nibble did not follow low nibble");
   AST_TX_MAX: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R12
      tx_st == mpli_pkg::TX_DATA |-> tx_cnt < mpli_pkg::MAX_LEN)
      else $error("frame longer than maximum");
   AST_TX_MIN: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R12
      (tx_st == mpli_pkg::TX_DATA && next_tx_st == mpli_pkg::TX_IDLE && tx_done) |-> tx_cnt_n >= mpli_pkg::MIN_LEN)
      else $error("completed frame shorter than minimum");
   AST_TX_LINK_MODE: assert property (@(posedge tx_clk_i) disable iff (!tx_rstn) // R14 R16
      (tx_st == mpli_pkg::TX_IDLE && next_tx_st == mpli_pkg::TX_PRE) |-> txs_s[0] ##1 tx_ser == $past(txs_s[1]))
      else $error("frame started without link or with wrong mode");
   // checks on the receive domain
   AST_RX_SFD: assert property (@(posedge rx_clk_i) disable iff (!rx_rstn) // R4 R8
      (rx_st == mpli_pkg::RX_PRE && rxp.dv && !rx_ser && rxp.d == mpli_pkg::SFD_NIB) |=> rx_st == mpli_pkg::RX_DATA)
      else $error("nibble delimiter missed");
   AST_RX_COL: assert property (@(posedge rx_clk_i) disable iff (!rx_rstn) // R6
      (rx_st != mpli_pkg::RX_IDLE && rxp.col) |=> rx_col)
      else $error("collision not recorded");
   COV_TX_SERIAL: cover property (@(posedge tx_clk_i) disable iff (!tx_rstn)
      tx_ser && tx_st == mpli_pkg::TX_DATA ##1 tx_st == mpli_pkg::TX_IDLE);
   COV_TX_NIBBLE_PAD: cover property (@(posedge tx_clk_i) disable iff (!tx_rstn)
      !tx_ser && tx_done && tx_st == mpli_pkg::TX_DATA && tx_bend);
   COV_RX_FRAME: cover property (@(posedge clock_i) disable iff (!rstn_i) rx_valid_o && rx_last_o && !rx_err_o);
endmodule

/* File: logic/mpli_pkg.sv */
// constants and carriers of the mii link interface toward an external phy.
// assumes the phy supplies both link clocks and that frame bytes go lsb first.
package mpli_pkg;

   // frame framing: seven preamble bytes then the delimiter byte, lsb first
   localparam logic [7:0]  PRE_BYTE  = 8'h55;    // 1010.. on the wire
   localparam logic [7:0]  SFD_BYTE  = 8'hd5;    // ends the 62+2 bit preamble
   localparam logic [3:0]  SFD_NIB   = 4'hd;     // delimiter's high nibble, sent after its low 5
   localparam logic [2:0]  PRE_BYTES = 3'h7;     // preamble bytes before delimiter

   // data field length in bytes
   localparam int          LEN_W     = 11;
   localparam logic [10:0] MIN_LEN   = 11'h040;  // 64
   localparam logic [10:0] MAX_LEN   = 11'h5ee;  // 1518
   localparam logic [10:0] LEN_SAT   = 11'h7ff;

   // last unit index inside a byte per lane mode
   localparam logic [2:0]  SER_LAST  = 3'h7;     // 8 single bits
   localparam logic [2:0]  NIB_LAST  = 3'h1;     // 2 nibbles

   // crossing ring depth as address bits
   localparam int          RING_AW   = 2;

   typedef struct packed
   {
      logic       last;
      logic [7:0] data;
   } mpli_tx_ent_t;

   typedef struct packed
   {
      logic       err;
      logic       last;
      logic [7:0] data;
   } mpli_rx_ent_t;

   typedef struct packed
   {
      logic       dv;
      logic       col;
      logic [3:0] d;
   } mpli_rx_pins_t;

   typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA} mpli_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA} mpli_rx_st_t;

endpackage

/* File: sim/mpli_phy_model.sv */
// phy stand-in: makes both link clocks, records sent units, plays frames in
// assumes the bench calls send_frame only between its own receive frames
module mpli_phy_model (
   output logic            tx_clk_o, // transmit clock
   output logic            rx_clk_o, // receive clock
   input  wire logic       tx_en_i,  // transmit valid
   input  wire logic [3:0] txd_i,    // transmit lanes
   output logic            rxdv_o,   // receive valid
   output logic [3:0]      rxd_o,    // receive lanes
   output logic            col_o     // collision; no mdc/mdio here
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] tq[$];
   // free running clocks, receive one out of phase
   initial
   begin
      tx_clk_o = 1'b0;
      rx_clk_o = 1'b0;
      {rxdv_o, rxd_o, col_o} = 6'h00;
      #37;
      forever #80 rx_clk_o = ~rx_clk_o;
   end
   always #80 tx_clk_o = ~tx_clk_o; // one rate serves both modes
   // sample on rising edge; idle lanes keep moving so stale data never matches
   always @(posedge tx_clk_o) if (tx_en_i) tq.push_back(txd_i);
   always @(negedge rx_clk_o) if (!rxdv_o) rxd_o <= ~rxd_o;
   // frame in either mode, lsb or low nibble first; the 1 ns lag keeps clear of the idle toggle
   task automatic send_frame(input logic [7:0] b[$], input logic col, input logic ser);
      int i;
      for (i = 0; i < (ser ? 64 + 8 * b.size() : 16 + 2 * b.size()); i++)
      begin
         @(negedge rx_clk_o);
         #1;
         rxdv_o = 1'b1;
         col_o  = col && i == 40;
         if (ser)
            rxd_o = {3'h0, i < 64 ? (i > 61 || !i[0]) : b[i/8-8][i%8]};
         else
            rxd_o = i < 15 ? 4'h5 : i == 15 ? 4'hd : i[0] ? b[i/2-8][7:4] : b[i/2-8][3:0];
      end
      @(negedge rx_clk_o);
      #1;
      {rxdv_o, col_o} = 2'b00;
   endtask
endmodule

/* File: sim/mpli_link_tb_top.sv */
// bench of the mii link: random frames both ways through a phy stand-in
// assumes clock_i at 50 MHz and link clocks made by the phy model
module mpli_link_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("ERROR %0t %h %h", $time, a, e); end end
   logic        clock_i    = 1'b0;
   logic        rstn_i     = 1'b0;
   logic        tx_valid_i = 1'b0;
   logic        tx_last_i  = 1'b0;
   logic [7:0]  tx_data_i  = 8'h00;
   logic [2:0]  st_n       = 3'h2; // link, serial, duplex pins
   logic [31:0] seed       = 32'h0000_2223;
   logic        tx_ready_o, rx_valid_o, rx_last_o, rx_err_o, tx_clk, rx_clk, tx_en, rxdv, col, last_err;
   logic [7:0]  rx_data_o;
   logic [3:0]  txd, rxd;
   logic [2:0]  st;
   logic [7:0]  fr[$], rq[$];
   logic [3:0]  eq[$];
   int          fail_count = 0, compares = 0, cycles = 0, i;
   mpli_link u_mpli_link (.clock_i, .rstn_i, .tx_valid_i, .tx_data_i, .tx_last_i, .tx_ready_o, .rx_valid_o, .rx_data_o,
      .rx_last_o, .rx_err_o, .link_up_o(st[2]), .serial_mode_o(st[1]), .full_duplex_o(st[0]),
      .link_status_n_i(st_n[2]), .serial_status_n_i(st_n[1]), .full_duplex_status_n_i(st_n[0]), .tx_clk_i(tx_clk),
      .transmit_valid_out_o(tx_en), .txd_o(txd), .rx_clk_i(rx_clk), .rxdv_i(rxdv), .rxd_i(rxd), .col_i(col));
   mpli_phy_model u_mpli_phy_model (.tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .tx_en_i(tx_en), .txd_i(txd),
      .rxdv_o(rxdv), .rxd_o(rxd), .col_o(col));
   always #10 clock_i = ~clock_i;
   // gather received bytes; cut a hang well past the longest run
   always @(negedge clock_i)
   begin
      cycles++;
      if (rx_valid_o === 1'b1) rq.push_back(rx_data_o);
      if (rx_valid_o === 1'b1 && rx_last_o === 1'b1) last_err = rx_err_o;
      if (cycles == 20000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // expected lane units: preamble, delimiter, data padded to minimum
   function automatic void wire_of(input logic ser);
      int k;
      eq = {};
      for (k = 0; k < (ser ? 64 : 16); k++) eq.push_back(ser ? {3'h0, k > 61 || !k[0]} : (k < 15 ? 4'h5 : 4'hd));
      while (fr.size() < 64) fr.push_back(8'h00);
      for (k = 0; k < fr.size() * (ser ? 8 : 2); k++)
         eq.push_back(ser ? {3'h0, fr[k/8][k%8]} : fr[k/2][4*(k%2)+:4]);
   endfunction
   // byte stays offered until seen taken; valid held across bytes
   task automatic send_tx(input int n, input logic ser);
      int k;
      st_n[1] = ~ser;
      fr = {};
      u_mpli_phy_model.tq = {};
      tx_valid_i = 1'b1;
      for (k = 0; k < n; k++)
      begin
         fr.push_back(rnd());
         tx_data_i = fr[k];
         tx_last_i = k == n - 1;
         while (tx_ready_o !== 1'b1) @(negedge clock_i);
         @(negedge clock_i);
      end
      tx_valid_i = 1'b0;
      tx_last_i  = 1'b0;
      wire_of(ser);
      while (u_mpli_phy_model.tq.size() < eq.size()) @(negedge clock_i);
      repeat (200) @(negedge clock_i);
      `CHK(u_mpli_phy_model.tq.size(), eq.size())
      foreach (eq[j]) `CHK(u_mpli_phy_model.tq[j], eq[j])
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // reset spans link clock edges too, else the link side is never reset
   initial
   begin
      repeat (3) @(posedge rx_clk);
      @(negedge clock_i);
      rstn_i = 1'b1;
      for (i = 0; i < 6; i++)
      begin
         st_n = 3'(rnd());
         repeat (4) @(negedge clock_i);
         `CHK(st, ~st_n)
      end
      st_n = 3'h2;
      send_tx(64, 1'b0);
      send_tx(3, 1'b1);
      for (i = 0; i < 3; i++)
      begin
         st_n = {1'b0, ~i[1], 1'b0};
         fr   = {};
         rq   = {};
         repeat (64) fr.push_back(rnd());
         // mode pin must cross into the receive domain before valid rises
         repeat (40) @(negedge clock_i);
         u_mpli_phy_model.send_frame(fr, i[0], i[1]);
         repeat (100) @(negedge clock_i);
         `CHK(rq.size(), 64)
         foreach (fr[j]) `CHK(rq[j], fr[j])
         `CHK(last_err, i[0])
      end
      end_of_test();
   end
endmodule
